// *** core/fwsr_pkg.sv ***
package fwsr_pkg;

   // ----------------------------------------------------------------
   // Bus constants
   // ----------------------------------------------------------------
   localparam int ADDR_W = 21;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_ONE_BIT = 6;
   localparam int LIMIT_BIT = 5;
   localparam int TOGGLE_TWO_BIT = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int CYCLE_NS = 1_000_000_000 / CLK_HZ;
   // Strobe low time for one read or write cycle.
   localparam int STROBE_NS = 200;
   localparam int STROBE_CYC = (STROBE_NS + CYCLE_NS - 1) / CYCLE_NS;
   // Default watchdog: 100 ms of polling before giving up.
   localparam int WATCHDOG_MS = 100;
   localparam int WATCHDOG_CYC = WATCHDOG_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 24;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RES_NONE = 3'h0,
      RES_DONE = 3'h1,
      RES_SUSPENDED = 3'h2,
      RES_LIMIT_FAIL = 3'h3,
      RES_WATCHDOG = 3'h4
   } fwsr_result_type;

   typedef enum logic [1:0] {
      MODE_TOGGLE = 2'h0,
      MODE_DATA_POLL = 2'h1
   } fwsr_mode_type;

   typedef struct packed {
      logic start;
      fwsr_mode_type mode;
      logic eraseOp;
      logic [ADDR_W-1:0] statusAddr;
      logic [7:0] expectData;
   } fwsr_req_type;

   typedef struct packed {
      logic chipEnable_n;
      logic outputEnable_n;
      logic writeEnable_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0] dataOut;
      logic dataOutEn;
   } fwsr_bus_type;

   typedef struct packed {
      logic busy;
      logic done;
      fwsr_result_type result;
      logic [7:0] lastByte;
      logic toggleTwoSeen;
   } fwsr_rsp_type;

endpackage

// *** core/fwsr_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// One asynchronous bus cycle: read or write, strobes held STROBE_CYC.
// ----------------------------------------------------------------
module fwsr_cycle (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Request
   input wire logic go,
   input wire logic isWrite,
   input wire logic [fwsr_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   // Answer
   output logic ack,
   output logic [7:0] rdata,
   // Pins
   output fwsr_pkg::fwsr_bus_type bus,
   input wire logic [7:0] dataIn
);

   typedef enum logic [2:0] {
      C_IDLE = 3'b001,
      C_ACT = 3'b010,
      C_REC = 3'b100
   } fwsr_cstate_type;

   typedef struct packed {
      fwsr_cstate_type st;
      logic [7:0] cnt;
      logic ack;
      logic [7:0] rdata;
      fwsr_pkg::fwsr_bus_type bus;
   } fwsr_cyc_type;

   fwsr_cyc_type r, next_r;

   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      case (r.st)
         C_IDLE: begin
            if (go) begin
               next_r.st = C_ACT;
               next_r.cnt = 8'(fwsr_pkg::STROBE_CYC);
               next_r.bus.addr = addr;
               next_r.bus.dataOut = wdata;
               next_r.bus.dataOutEn = isWrite;
               next_r.bus.chipEnable_n = 1'b0;
               next_r.bus.outputEnable_n = isWrite;
               next_r.bus.writeEnable_n = !isWrite;
            end
         end
         C_ACT: begin
            next_r.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01) begin
               // Sample before the strobe rises so data is still driven.
               next_r.rdata = dataIn;
               next_r.bus.chipEnable_n = 1'b1;
               next_r.bus.outputEnable_n = 1'b1;
               next_r.bus.writeEnable_n = 1'b1;
               next_r.st = C_REC;
            end
         end
         C_REC: begin
            // At least two cycles with strobes high (this one and C_IDLE) separate cycles so each read is a distinct edge.
            next_r.bus.dataOutEn = 1'b0;
            next_r.ack = 1'b1;
            next_r.st = C_IDLE;
         end
         default: next_r.st = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r.st <= C_IDLE;
         r.cnt <= 8'h00;
         r.ack <= 1'b0;
         r.rdata <= 8'h00;
         r.bus <= '{chipEnable_n: 1'b1, outputEnable_n: 1'b1, writeEnable_n: 1'b1,
                    addr: '0, dataOut: 8'h00, dataOutEn: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign ack = r.ack;
   assign rdata = r.rdata;
   assign bus = r.bus;

endmodule

`default_nettype wire

// *** core/fwsr_poller.sv ***
`timescale 1ns/1ps
`default_nettype none


module fwsr_poller #(
   parameter int WATCHDOG_CYC = fwsr_pkg::WATCHDOG_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // User request and answer
   input wire fwsr_pkg::fwsr_req_type req,
   output fwsr_pkg::fwsr_rsp_type rsp,
   // Flash pins
   output fwsr_pkg::fwsr_bus_type bus,
   input wire logic [7:0] dataIn,
   input wire logic readyBusyIn
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      S_IDLE = 8'b00000001,
      S_READ1 = 8'b00000010,
      S_READ2 = 8'b00000100,
      S_RECHECK = 8'b00001000,
      S_FINAL = 8'b00010000,
      S_RESET = 8'b00100000,
      S_REPORT = 8'b01000000,
      S_WAIT = 8'b10000000
   } fwsr_state_type;

   typedef struct packed {
      fwsr_state_type st;
      fwsr_pkg::fwsr_req_type job;
      logic [7:0] prevByte;
      logic [fwsr_pkg::CNT_W-1:0] watchdog;
      logic go;
      logic isWrite;
      logic sawToggleTwo;
      fwsr_pkg::fwsr_result_type pend;
      fwsr_pkg::fwsr_rsp_type rsp;
   } fwsr_poll_type;

   fwsr_poll_type r, next_r;
   logic cycAck;
   logic [7:0] cycData;

   // Completion test for one status byte against the previous one.
   function automatic logic is_toggling(input logic [7:0] a, input logic [7:0] b);
      is_toggling = a[fwsr_pkg::TOGGLE_ONE_BIT] != b[fwsr_pkg::TOGGLE_ONE_BIT];
   endfunction

   function automatic logic poll_done(input logic [7:0] d, input fwsr_pkg::fwsr_req_type j);
      // Erase ends with a 1; program ends with the true written value.
      poll_done = j.eraseOp ? d[fwsr_pkg::POLL_BIT]
                            : (d[fwsr_pkg::POLL_BIT] == j.expectData[fwsr_pkg::POLL_BIT]);
   endfunction

   // ----------------------------------------------------------------
   // Bus cycle engine
   // ----------------------------------------------------------------
   fwsr_cycle u_cycle (
      .clk_sys(clk_sys),
      .rst(rst),
      .go(r.go),
      .isWrite(r.isWrite),
      .addr(r.job.statusAddr),
      .wdata(fwsr_pkg::CMD_RESET),
      .ack(cycAck),
      .rdata(cycData),
      .bus(bus),
      .dataIn(dataIn)
   );

   // ----------------------------------------------------------------
   // Polling sequence
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.go = 1'b0;
      next_r.rsp.done = 1'b0;
      // The count stops at zero, so a wrap can never carry it past the expiry test.
      if (r.st != S_IDLE && r.st != S_RESET && r.st != S_REPORT && r.watchdog != '0) begin
         next_r.watchdog = r.watchdog - fwsr_pkg::CNT_W'(1);
      end
      case (r.st)
         S_IDLE: begin
            if (req.start) begin
               // Every new request restarts from the first double read.
               next_r.job = req;
               next_r.watchdog = fwsr_pkg::CNT_W'(WATCHDOG_CYC);
               next_r.sawToggleTwo = 1'b0;
               next_r.rsp.busy = 1'b1;
               next_r.rsp.result = fwsr_pkg::RES_NONE;
               next_r.st = S_WAIT;
            end
         end
         S_WAIT: begin
            // Issue the next read at the valid status address.
            next_r.go = 1'b1;
            next_r.isWrite = 1'b0;
            next_r.st = S_READ1;
         end
         S_READ1: begin
            if (cycAck) begin
               next_r.prevByte = cycData;
               next_r.rsp.lastByte = cycData;
               next_r.go = 1'b1;
               next_r.st = S_READ2;
            end
         end
         S_READ2, S_RECHECK: begin
            if (cycAck) begin
               next_r.rsp.lastByte = cycData;
               if (is_toggling(cycData, r.prevByte) &&
                   cycData[fwsr_pkg::TOGGLE_TWO_BIT] != r.prevByte[fwsr_pkg::TOGGLE_TWO_BIT]) begin
                  next_r.sawToggleTwo = 1'b1;
               end
               if (r.job.mode == fwsr_pkg::MODE_DATA_POLL ? poll_done(cycData, r.job)
                                                       : !is_toggling(cycData, r.prevByte)) begin
                  // Status bits may be stale; take the byte from one more read.
                  next_r.pend = (!r.job.eraseOp || readyBusyIn) &&
                                r.job.mode == fwsr_pkg::MODE_TOGGLE &&
                                cycData[fwsr_pkg::TOGGLE_TWO_BIT] !=
                                r.prevByte[fwsr_pkg::TOGGLE_TWO_BIT] ?
                                fwsr_pkg::RES_SUSPENDED : fwsr_pkg::RES_DONE;
                  next_r.go = 1'b1;
                  next_r.st = S_FINAL;
               end else if (r.st == S_RECHECK) begin
                  // Still active after the limit flag rose: failed.
                  next_r.pend = fwsr_pkg::RES_LIMIT_FAIL;
                  next_r.isWrite = 1'b1;
                  next_r.go = 1'b1;
                  next_r.st = S_RESET;
               end else if (cycData[fwsr_pkg::LIMIT_BIT]) begin
                  next_r.prevByte = cycData;
                  next_r.go = 1'b1;
                  next_r.st = S_RECHECK;
               end else if (r.watchdog == '0) begin
                  next_r.pend = fwsr_pkg::RES_WATCHDOG;
                  next_r.isWrite = 1'b1;
                  next_r.go = 1'b1;
                  next_r.st = S_RESET;
               end else begin
                  next_r.prevByte = cycData;
                  next_r.go = 1'b1;
               end
            end
         end
         S_FINAL: begin
            if (cycAck) begin
               next_r.rsp.lastByte = cycData;
               next_r.st = S_REPORT;
            end
         end
         S_RESET: begin
            // Single reset write returns the device to reading.
            if (cycAck) begin
               next_r.isWrite = 1'b0;
               next_r.st = S_REPORT;
            end
         end
         S_REPORT: begin
            next_r.rsp.result = r.pend;
            next_r.rsp.toggleTwoSeen = r.sawToggleTwo;
            next_r.rsp.busy = 1'b0;
            next_r.rsp.done = 1'b1;
            next_r.st = S_IDLE;
         end
         default: next_r.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r <= '0;
         r.st <= S_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign rsp = r.rsp;

endmodule

`default_nettype wire

// *** tb/fwsr_poller_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller_properties #(
   parameter int WATCHDOG_CYC = fwsr_pkg::WATCHDOG_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Watched ports
   input wire fwsr_pkg::fwsr_req_type req,
   input wire fwsr_pkg::fwsr_rsp_type rsp,
   input wire fwsr_pkg::fwsr_bus_type bus,
   input wire logic [7:0] dataIn,
   input wire logic readyBusyIn
);
   // ----
   // Job history
   // ----
   logic [fwsr_pkg::ADDR_W-1:0] jobAddr;
   logic [3:0] reads;
   logic limitSeen;
   logic taken;
   int busyCnt;
   assign taken = req.start && !rsp.busy;
   always_ff @(posedge clk_sys) begin
      if (rst || taken) begin
         jobAddr <= req.statusAddr;
         reads <= 4'h0;
         limitSeen <= 1'b0;
         busyCnt <= 0;
      end else begin
         if (!bus.chipEnable_n && !bus.outputEnable_n && dataIn[fwsr_pkg::LIMIT_BIT]) begin
            limitSeen <= 1'b1;
         end
         if ($rose(bus.outputEnable_n) && reads != 4'hf) begin
            reads <= reads + 4'h1;
         end
         if (rsp.busy) begin
            busyCnt <= busyCnt + 1;
         end
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence s_release(logic pin);
      !pin ##1 pin;
   endsequence
   a_read_strobe_width: assert property ($fell(bus.outputEnable_n) |=> s_release(bus.outputEnable_n))
      else $error("read strobe not two cycles");
   a_write_strobe_width: assert property ($fell(bus.writeEnable_n) |=> s_release(bus.writeEnable_n))
      else $error("write strobe not two cycles");
   a_reset_cmd_data: assert property (!bus.writeEnable_n |-> !bus.chipEnable_n && bus.outputEnable_n
      && bus.dataOutEn && bus.dataOut == fwsr_pkg::CMD_RESET)
      else $error("write is not the reset command");
   a_reset_after_limit: assert property ($fell(bus.writeEnable_n) |->
      limitSeen || busyCnt >= WATCHDOG_CYC)
      else $error("reset written without limit flag or watchdog expiry");
   a_status_addr: assert property (!bus.outputEnable_n |-> bus.addr == jobAddr && !bus.dataOutEn)
      else $error("status read at wrong address");
   a_done_reads: assert property (rsp.done && rsp.result == fwsr_pkg::RES_DONE |-> reads >= 4'h2)
      else $error("completion with too few reads");
   a_limit_result: assert property (rsp.done && rsp.result == fwsr_pkg::RES_LIMIT_FAIL |-> limitSeen)
      else $error("limit failure without limit flag");
   a_done_pulse: assert property (rsp.done |=> !rsp.done && !rsp.busy)
      else $error("done longer than one cycle");
   a_watchdog_bound: assert property (busyCnt <= WATCHDOG_CYC + 100)
      else $error("polling exceeded watchdog");
endmodule
bind fwsr_poller fwsr_poller_properties #(.WATCHDOG_CYC(WATCHDOG_CYC)) i_fwsr_poller_properties (
   .clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp), .bus(bus), .dataIn(dataIn),
   .readyBusyIn(readyBusyIn));
`default_nettype wire

// *** tb/fwsr_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
   // Clock and scenario
   input wire logic clk_sys,
   input wire logic load,
   input wire logic eraseOp,
   input wire logic suspend,
   input wire logic failLimit,
   input wire logic [7:0] busyReads,
   input wire logic [7:0] arrayByte,
   // Pins
   input wire fwsr_pkg::fwsr_bus_type bus,
   output logic [7:0] dataBus,
   output logic readyBusy
);
   logic busy, susp, erase, tog1, tog2, limit, rd, wr, rdPrev, wrPrev;
   logic [7:0] left, status, lastOut;
   assign rd = !bus.chipEnable_n && !bus.outputEnable_n;
   assign wr = !bus.chipEnable_n && !bus.writeEnable_n;
   always_ff @(posedge clk_sys) begin
      rdPrev <= rd;
      wrPrev <= wr;
      if (rd || load) begin
         lastOut <= status;
      end
      if (load) begin
         busy <= !suspend;
         susp <= suspend;
         erase <= eraseOp;
         left <= busyReads;
         {tog1, tog2, limit} <= 3'h0;
      end else if (rdPrev && !rd) begin
         if (busy) begin
            tog1 <= !tog1;
            if (left != 8'h00) begin
               left <= left - 8'h01;
            end else if (failLimit) begin
               limit <= 1'b1;
            end else begin
               // A protected target looks the same outside: a fixed busy span, then array data.
               busy <= 1'b0;
            end
         end
         if ((busy || susp) && erase) begin
            tog2 <= !tog2;
         end
      end else if (wrPrev && !wr && bus.dataOut == fwsr_pkg::CMD_RESET) begin
         busy <= 1'b0;
         limit <= 1'b0;
      end
   end
   always_comb begin
      status = {!erase && !arrayByte[7], tog1, limit, 2'h0, erase && tog2, 2'h0};
      if (susp && !busy) begin
         status = {1'b1, tog1, 1'b0, 2'h0, tog2, 2'h0};
      end
      if (!busy && !susp) begin
         status = arrayByte;
      end
      // Released bus shows the inverse so a stale value is never mistaken for data.
      dataBus = rd ? status : ~lastOut;
      readyBusy = !busy;
   end
endmodule
`default_nettype wire

// *** tb/fwsr_poller_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic load = 1'b1;
   logic eraseOp = 1'b0;
   logic suspend = 1'b0;
   logic failLimit = 1'b0;
   logic [7:0] busyReads = 8'h00;
   logic [7:0] arrayByte = 8'h00;
   logic [7:0] flashData;
   logic [7:0] dataIn;
   logic readyBusy;
   fwsr_pkg::fwsr_req_type req = '0;
   fwsr_pkg::fwsr_rsp_type rsp;
   fwsr_pkg::fwsr_bus_type bus;
   int errors = 0;
   int checks = 0;
   always #50 clk_sys = ~clk_sys;
   assign dataIn = bus.dataOutEn ? bus.dataOut : flashData;
   fwsr_poller #(.WATCHDOG_CYC(200)) i_fwsr_poller (.clk_sys(clk_sys), .rst(rst), .req(req),
      .rsp(rsp), .bus(bus), .dataIn(dataIn), .readyBusyIn(readyBusy));
   fwsr_flash_model i_fwsr_flash_model (.clk_sys(clk_sys), .load(load), .eraseOp(eraseOp),
      .suspend(suspend), .failLimit(failLimit), .busyReads(busyReads), .arrayByte(arrayByte),
      .bus(bus), .dataBus(flashData), .readyBusy(readyBusy));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
      checks++;
      if (seen !== expected) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, expected, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic run_job(input fwsr_pkg::fwsr_mode_type mode, input logic erase,
      input logic susp, input logic fail, input logic [7:0] reads, input logic [7:0] data);
      int n;
      @(negedge clk_sys);
      {eraseOp, suspend, failLimit, busyReads, arrayByte, load} = {erase, susp, fail, reads, data, 1'b1};
      @(negedge clk_sys);
      load = 1'b0;
      req = '{start: 1'b1, mode: mode, eraseOp: erase, statusAddr: {13'h0, data}, expectData: data};
      @(negedge clk_sys);
      req.start = 1'b0;
      n = 0;
      while (rsp.done !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (rsp.done !== 1'b1) begin
         errors++;
      end
   endtask
   task automatic program_toggle;
      run_job(fwsr_pkg::MODE_TOGGLE, 1'b0, 1'b0, 1'b0, 8'h05, 8'h3c);
      check("program result", {5'h0, rsp.result}, 8'h01);
      check("program byte", rsp.lastByte, 8'h3c);
      check("ready", {7'h0, readyBusy}, 8'h01);
   endtask
   task automatic program_poll;
      run_job(fwsr_pkg::MODE_DATA_POLL, 1'b0, 1'b0, 1'b0, 8'h06, 8'hc3);
      check("poll result", {5'h0, rsp.result}, 8'h01);
      check("poll byte", rsp.lastByte, 8'hc3);
   endtask
   task automatic erase_toggle;
      run_job(fwsr_pkg::MODE_TOGGLE, 1'b1, 1'b0, 1'b0, 8'h04, 8'hff);
      check("erase result", {5'h0, rsp.result}, 8'h01);
      check("erase bit two", {7'h0, rsp.toggleTwoSeen}, 8'h01);
   endtask
   task automatic erase_poll;
      run_job(fwsr_pkg::MODE_DATA_POLL, 1'b1, 1'b0, 1'b0, 8'h00, 8'hff);
      check("erase poll result", {5'h0, rsp.result}, 8'h01);
   endtask
   task automatic erase_suspend;
      run_job(fwsr_pkg::MODE_TOGGLE, 1'b1, 1'b1, 1'b0, 8'h00, 8'hff);
      check("suspend result", {5'h0, rsp.result}, 8'h02);
   endtask
   task automatic limit_fail;
      run_job(fwsr_pkg::MODE_TOGGLE, 1'b0, 1'b0, 1'b1, 8'h02, 8'h5a);
      check("limit result", {5'h0, rsp.result}, 8'h03);
      check("ready after reset", {7'h0, readyBusy}, 8'h01);
   endtask
   task automatic watchdog_expiry;
      run_job(fwsr_pkg::MODE_TOGGLE, 1'b0, 1'b0, 1'b0, 8'hff, 8'h81);
      check("watchdog result", {5'h0, rsp.result}, 8'h04);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      complete_run();
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      load = 1'b0;
      program_toggle();
      program_poll();
      erase_toggle();
      erase_poll();
      erase_suspend();
      limit_fail();
      program_toggle();
      watchdog_expiry();
      complete_run();
   end
endmodule
`default_nettype wire
